// File: core/adc_port_pkg.sv
// Constants shared by the serial control port of the converter
package adc_port_pkg;
    localparam int OSC_HZ              = 25000000;
    localparam int TRISTATE_MIN_OSC    = 6;
    localparam int TRISTATE_MAX_OSC    = 10;
    localparam int RESULT_INVALID_OSC  = 4;
    localparam int RESULT_WIDTH        = 24;
    localparam int CMD_WIDTH           = 8;
    localparam int PORT_PINS           = 8;
    localparam int CONV_PERIOD_DEFAULT = 8192;
    localparam int CNT_WIDTH           = 16;
    localparam logic [7:0] CMD_READ_ONCE       = 8'h01;
    localparam logic [7:0] CMD_READ_CONTINUOUS = 8'h03;
    localparam logic [7:0] CMD_STOP_CONTINUOUS = 8'h0F;
    localparam logic [7:0] CMD_RESET           = 8'hFE;
    typedef enum logic [1:0] {
        shift_command,
        shift_result,
        shift_idle
    } shift_state_type;
endpackage

// File: core/adc_edge_if.sv
// Synchronised serial pin levels and edge events passed to the shifter
`timescale 1ns/100ps
`default_nettype none
interface adc_edge_if;
    logic select;
    logic data_in;
    logic rise;
    logic fall;
    modport source (output select, output data_in, output rise, output fall);
    modport sink   (input select, input data_in, input rise, input fall);
endinterface
`default_nettype wire

// File: core/adc_pin_sync.sv
// Two-stage synchronisers and serial clock edge finder
`timescale 1ns/100ps
`default_nettype none
module adc_pin_sync (
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   chip_select_n,
    input  wire logic   serial_clock,
    input  wire logic   serial_data_in,
    adc_edge_if.source  edges
);
    logic [2:0] first;
    logic [2:0] second;
    logic       clock_last;
    logic [2:0] next_first;
    logic [2:0] next_second;
    logic       next_clock_last;

    always_comb begin
        next_first      = {~chip_select_n, serial_clock, serial_data_in};
        next_second     = first;
        next_clock_last = second[1];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            first      <= 3'h0;
            second     <= 3'h0;
            clock_last <= 1'b0;
        end else begin
            first      <= next_first;
            second     <= next_second;
            clock_last <= next_clock_last;
        end
    end

    assign edges.select  = second[2];
    assign edges.data_in = second[0];
    assign edges.rise    = second[1] & ~clock_last;
    assign edges.fall    = ~second[1] & clock_last;
endmodule
`default_nettype wire

// File: core/adc_serial_port.sv
// Serial control port sequencing of the converter
`timescale 1ns/100ps
`default_nettype none
module adc_serial_port
    import adc_port_pkg::*;
#(
    parameter int CONV_PERIOD = CONV_PERIOD_DEFAULT
) (
    input  wire logic                                   clk,
    input  wire logic                                   rst,
    input  wire logic                                   power_down_n,
    input  wire logic                                   chip_select_n,
    input  wire logic                                   serial_clock,
    input  wire logic                                   serial_data_in,
    input  wire logic [adc_port_pkg::RESULT_WIDTH-1:0]  sample_value,
    input  wire logic [adc_port_pkg::PORT_PINS-1:0]     port_mode_digital,
    input  wire logic [adc_port_pkg::PORT_PINS-1:0]     port_out_value,
    input  wire logic [adc_port_pkg::PORT_PINS-1:0]     port_pin_in,
    output logic                                        serial_data_out,
    output logic                                        serial_data_out_en,
    output logic                                        conversion_ready_n,
    output logic [adc_port_pkg::PORT_PINS-1:0]          port_pin_out,
    output logic [adc_port_pkg::PORT_PINS-1:0]          port_pin_oe,
    output logic [adc_port_pkg::PORT_PINS-1:0]          port_read_value,
    output logic                                        analog_enable
);
    import adc_port_pkg::*;

    localparam int TRI_CYCLES = (TRISTATE_MIN_OSC + TRISTATE_MAX_OSC) / 2;

    adc_edge_if edges ();

    adc_pin_sync sync_inst (
        .clk            (clk),
        .rst            (rst),
        .chip_select_n  (chip_select_n),
        .serial_clock   (serial_clock),
        .serial_data_in (serial_data_in),
        .edges          (edges)
    );

    logic [PORT_PINS-1:0] pin_meta;
    logic [PORT_PINS-1:0] pin_sync;
    logic                 down_meta;
    logic                 down_sync;

    shift_state_type        state;
    shift_state_type        next_state;
    logic [CNT_WIDTH-1:0]   conv_count;
    logic [CNT_WIDTH-1:0]   next_conv_count;
    logic [RESULT_WIDTH-1:0] holding;
    logic [RESULT_WIDTH-1:0] next_holding;
    logic [2:0]             invalid_count;
    logic [2:0]             next_invalid_count;
    logic [RESULT_WIDTH-1:0] shifter;
    logic [RESULT_WIDTH-1:0] next_shifter;
    logic [4:0]             bit_count;
    logic [4:0]             next_bit_count;
    logic [3:0]             idle_count;
    logic [3:0]             next_idle_count;
    logic                   continuous;
    logic                   next_continuous;
    logic                   next_data_out;
    logic                   next_data_out_en;
    logic                   next_ready_n;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_meta  <= '0;
            pin_sync  <= '0;
            down_meta <= 1'b0;
            down_sync <= 1'b0;
        end else begin
            pin_meta  <= port_pin_in;
            pin_sync  <= pin_meta;
            down_meta <= power_down_n;
            down_sync <= down_meta;
        end
    end

    always_comb begin
        next_state         = state;
        next_conv_count    = conv_count + 1'b1;
        next_holding       = holding;
        next_invalid_count = (invalid_count != 3'h0) ? invalid_count - 1'b1 : 3'h0;
        next_shifter       = shifter;
        next_bit_count     = bit_count;
        next_idle_count    = (idle_count != 4'h0) ? idle_count - 1'b1 : 4'h0;
        next_continuous    = continuous;
        next_data_out      = serial_data_out;
        next_data_out_en   = serial_data_out_en;
        next_ready_n       = conversion_ready_n;
        if (conv_count == CNT_WIDTH'(CONV_PERIOD - 1)) begin
            next_conv_count = '0;
            // Result updates land only while no readout is in flight
            if (state != shift_result) begin
                next_holding       = sample_value;
                next_invalid_count = 3'(RESULT_INVALID_OSC);
                next_ready_n       = 1'b1;
            end
        end
        if (edges.rise && edges.select) begin
            next_idle_count = 4'(TRI_CYCLES);
        end
        if (idle_count == 4'h1) begin
            next_data_out_en = 1'b0;
        end
        case (state)
            shift_command: begin
                if (edges.rise && edges.select) begin
                    next_shifter   = {shifter[RESULT_WIDTH-2:0], edges.data_in};
                    next_bit_count = bit_count + 1'b1;
                    if (bit_count == 5'(CMD_WIDTH - 1)) begin
                        next_bit_count = '0;
                        case ({shifter[CMD_WIDTH-2:0], edges.data_in})
                            CMD_READ_ONCE: begin
                                next_state   = shift_result;
                                next_shifter = holding;
                            end
                            CMD_READ_CONTINUOUS: begin
                                next_continuous = 1'b1;
                            end
                            CMD_STOP_CONTINUOUS: begin
                                next_continuous = 1'b0;
                            end
                            CMD_RESET: begin
                                next_continuous = 1'b0;
                                next_conv_count = '0;
                            end
                            default: begin
                            end
                        endcase
                    end
                end else if (continuous && !conversion_ready_n && edges.rise && edges.select) begin
                    next_state = shift_result;
                end
            end
            shift_result: begin
                if (edges.rise && edges.select) begin
                    next_data_out    = shifter[RESULT_WIDTH-1];
                    next_data_out_en = 1'b1;
                    next_shifter     = {shifter[RESULT_WIDTH-2:0], 1'b0};
                    next_bit_count   = bit_count + 1'b1;
                    if (bit_count == 5'(RESULT_WIDTH - 1)) begin
                        next_bit_count = '0;
                        next_state     = shift_command;
                        next_ready_n   = 1'b1;
                    end
                end
            end
            default: begin
                next_state = shift_command;
            end
        endcase
        // In continuous mode readout starts from a ready result on first clock
        if (state == shift_command && continuous && !conversion_ready_n && bit_count == 5'h0
            && edges.rise && edges.select) begin
            next_state       = shift_result;
            next_data_out    = holding[RESULT_WIDTH-1];
            next_data_out_en = 1'b1;
            next_shifter     = {holding[RESULT_WIDTH-2:0], 1'b0};
            next_bit_count   = 5'h1;
        end
        // New result wins over a readout that ends in the same cycle
        if (invalid_count == 3'h1) begin
            next_ready_n = 1'b0;
        end
        if (!edges.select) begin
            next_data_out_en = 1'b0;
            next_bit_count   = '0;
            next_state       = shift_command;
        end
        if (!down_sync) begin
            // Power down clears sequencing; holding data is kept
            next_state       = shift_command;
            next_conv_count  = '0;
            next_data_out_en = 1'b0;
            next_ready_n     = 1'b1;
            next_continuous  = 1'b0;
            next_bit_count   = '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state              <= shift_command;
            conv_count         <= '0;
            holding            <= '0;
            invalid_count      <= 3'h0;
            shifter            <= '0;
            bit_count          <= '0;
            idle_count         <= 4'h0;
            continuous         <= 1'b0;
            serial_data_out    <= 1'b0;
            serial_data_out_en <= 1'b0;
            conversion_ready_n <= 1'b1;
        end else begin
            state              <= next_state;
            conv_count         <= next_conv_count;
            holding            <= next_holding;
            invalid_count      <= next_invalid_count;
            shifter            <= next_shifter;
            bit_count          <= next_bit_count;
            idle_count         <= next_idle_count;
            continuous         <= next_continuous;
            serial_data_out    <= next_data_out;
            serial_data_out_en <= next_data_out_en;
            conversion_ready_n <= next_ready_n;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_pin_out    <= '0;
            port_pin_oe     <= '0;
            port_read_value <= '0;
            analog_enable   <= 1'b0;
        end else begin
            port_pin_out    <= port_out_value & port_mode_digital;
            port_pin_oe     <= down_sync ? port_mode_digital : '0;
            port_read_value <= pin_sync & port_mode_digital;
            analog_enable   <= down_sync;
        end
    end
endmodule
`default_nettype wire

// File: sim/adc_serial_port_checker.sv
// Concurrent checks on the pins of the converter's serial control port
`timescale 1ns/100ps
`default_nettype none
module adc_serial_port_checker
    import adc_port_pkg::*;
#(
    parameter int CONV_PERIOD = CONV_PERIOD_DEFAULT
) (
    input wire logic                        clk,
    input wire logic                        rst,
    input wire logic                        power_down_n,
    input wire logic                        chip_select_n,
    input wire logic                        serial_clock,
    input wire logic [PORT_PINS-1:0]        port_mode_digital,
    input wire logic [PORT_PINS-1:0]        port_out_value,
    input wire logic                        serial_data_out_en,
    input wire logic                        conversion_ready_n,
    input wire logic [PORT_PINS-1:0]        port_pin_out,
    input wire logic [PORT_PINS-1:0]        port_pin_oe,
    input wire logic                        analog_enable
);
    import adc_port_pkg::*;
    logic [7:0]  idle_cnt, next_idle_cnt;
    logic [15:0] high_cnt, next_high_cnt;
    logic        sclk_prev, next_sclk_prev;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Pin edge counted, so the sync delay is part of the margin
    always_comb begin
        next_sclk_prev = serial_clock;
        next_idle_cnt  = (serial_clock && !sclk_prev) ? 8'h00 : idle_cnt + 8'(idle_cnt != 8'hFF);
        next_high_cnt  = (conversion_ready_n && power_down_n) ? high_cnt + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_prev <= 1'b0;
            idle_cnt  <= 8'hFF;
            high_cnt  <= 16'h0000;
        end else begin
            sclk_prev <= next_sclk_prev;
            idle_cnt  <= next_idle_cnt;
            high_cnt  <= next_high_cnt;
        end
    end
    sequence held_down;
        !power_down_n [*4];
    endsequence
    sequence stable_cfg;
        ($stable(port_mode_digital) && $stable(port_out_value) && power_down_n) [*5];
    endsequence
    a_float_deselect: assert property ($rose(chip_select_n) |-> ##[1:4] !serial_data_out_en)
        else $error("output still driven after deselect");
    a_float_late: assert property (serial_data_out_en |-> idle_cnt <= 8'd14)
        else $error("output driven too long after last clock");
    a_float_early: assert property ($fell(serial_data_out_en) && $past(chip_select_n) == 1'b0 && power_down_n |-> idle_cnt >= 8'd6)
        else $error("output released too early");
    a_power_off: assert property (held_down |-> !analog_enable && !serial_data_out_en)
        else $error("circuitry active during power down");
    a_power_back: assert property ($rose(power_down_n) |-> ##[1:8] analog_enable)
        else $error("analog not restored after power down");
    a_pins_dir: assert property (stable_cfg |-> port_pin_oe == port_mode_digital)
        else $error("pin direction differs from mode");
    a_pins_drive: assert property (stable_cfg |-> (port_pin_out & port_pin_oe) == (port_out_value & port_pin_oe))
        else $error("digital pin drives wrong level");
    a_ready_hold: assert property ($fell(conversion_ready_n) |=> !conversion_ready_n [*3])
        else $error("ready pulse too short");
    a_ready_period: assert property (high_cnt <= 16'(2 * CONV_PERIOD + 32))
        else $error("no new result within two periods");
endmodule
bind adc_serial_port adc_serial_port_checker #(.CONV_PERIOD(CONV_PERIOD)) checker_i (
    .clk                (clk),
    .rst                (rst),
    .power_down_n       (power_down_n),
    .chip_select_n      (chip_select_n),
    .serial_clock       (serial_clock),
    .port_mode_digital  (port_mode_digital),
    .port_out_value     (port_out_value),
    .serial_data_out_en (serial_data_out_en),
    .conversion_ready_n (conversion_ready_n),
    .port_pin_out       (port_pin_out),
    .port_pin_oe        (port_pin_oe),
    .analog_enable      (analog_enable)
);
`default_nettype wire

// File: sim/adc_host_model.sv
// Host serial master model for the converter's control port
`timescale 1ns/100ps
`default_nettype none
module adc_host_model (
    input  wire logic         clk,
    input  wire logic         data_out,
    input  wire logic         data_out_en,
    output var logic          chip_select_n,
    output var logic          serial_clock,
    output var logic          serial_data_in,
    output var logic          word_done,
    output var logic [23:0]   word
);
    logic line;
    logic line_last = 1'b0;
    // Released line toggles so a stale bit never passes
    assign line = data_out_en ? data_out : ~line_last;
    always @(posedge clk) line_last <= line;
    initial begin
        chip_select_n = 1'b1;
        serial_clock = 1'b0;
        serial_data_in = 1'b0;
        word_done = 1'b0;
        word = 24'h000000;
    end
    task idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task select(input logic on);
        idle(1);
        chip_select_n = ~on;
    endtask
    // Clock idles low outside frames, 8 system clocks a bit
    task send(input logic [7:0] cmd);
        for (int i = 7; i >= 0; i--) begin
            serial_data_in = cmd[i];
            idle(4);
            serial_clock = 1'b1;
            idle(4);
            serial_clock = 1'b0;
        end
    endtask
    task read(input int n);
        word = 24'h000000;
        for (int i = 0; i < n; i++) begin
            serial_clock = 1'b1;
            idle(4);
            serial_clock = 1'b0;
            idle(3);
            word = {word[22:0], line};
            idle(1);
        end
        word_done = 1'b1;
        idle(1);
        word_done = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: sim/adc_serial_port_tb.sv
// Self-checking bench for the converter's serial control port
`timescale 1ns/100ps
`default_nettype none
module adc_serial_port_tb;
    import adc_port_pkg::*;
    logic                    clk, rst, power_down_n, chip_select_n, serial_clock, serial_data_in, word_done;
    logic                    serial_data_out, serial_data_out_en, conversion_ready_n, analog_enable;
    logic [RESULT_WIDTH-1:0] sample_value, word;
    logic [PORT_PINS-1:0]    port_mode_digital, port_out_value, port_pin_in;
    logic [PORT_PINS-1:0]    port_pin_out, port_pin_oe, port_read_value;
    logic [31:0]             seed = 32'h0000002F;
    logic [23:0]             exp_q[$];
    int                      errors = 0;
    int                      tests_run = 0;
    localparam int           CONV_SIM = 200;
    // Code arbitrary; the port must ignore it
    localparam logic [7:0]   CMD_SELF_GAIN_CALIBRATE = 8'hF0;
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Short conversion period keeps the run brief
    adc_serial_port #(
        .CONV_PERIOD        (CONV_SIM)
    ) dut (
        .clk                (clk),
        .rst                (rst),
        .power_down_n       (power_down_n),
        .chip_select_n      (chip_select_n),
        .serial_clock       (serial_clock),
        .serial_data_in     (serial_data_in),
        .sample_value       (sample_value),
        .port_mode_digital  (port_mode_digital),
        .port_out_value     (port_out_value),
        .port_pin_in        (port_pin_in),
        .serial_data_out    (serial_data_out),
        .serial_data_out_en (serial_data_out_en),
        .conversion_ready_n (conversion_ready_n),
        .port_pin_out       (port_pin_out),
        .port_pin_oe        (port_pin_oe),
        .port_read_value    (port_read_value),
        .analog_enable      (analog_enable)
    );
    adc_host_model host (
        .clk                (clk),
        .data_out           (serial_data_out),
        .data_out_en        (serial_data_out_en),
        .chip_select_n      (chip_select_n),
        .serial_clock       (serial_clock),
        .serial_data_in     (serial_data_in),
        .word_done          (word_done),
        .word               (word)
    );
    function logic [31:0] rand32();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task check(input string what, input logic [23:0] exp, input logic [23:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task finish_test();
        $display("Comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) if (word_done === 1'b1) check("result", exp_q.pop_front(), word);
    initial begin
        repeat (12000) @(posedge clk);
        errors++;
        $display("ERROR watchdog expected done seen hang");
        finish_test();
    end
    task wait_ready();
        int n;
        for (n = 0; n < 1000 && conversion_ready_n !== 1'b0; n++) @(negedge clk);
        check("ready", 24'h0, 24'(conversion_ready_n));
    endtask
    task read_once();
        wait_ready();
        exp_q.push_back(sample_value);
        host.select(1'b1);
        host.send(CMD_READ_ONCE);
        host.idle(50);
        host.read(24);
        host.select(1'b0);
        sample_value = 24'(rand32());
        host.idle(4);
        $display("Test read once done");
    endtask
    task pins_check();
        port_mode_digital = 8'(rand32());
        port_out_value = 8'(rand32());
        port_pin_in = 8'(rand32());
        repeat (6) @(negedge clk);
        check("pin_dir", 24'(port_mode_digital), 24'(port_pin_oe));
        check("pin_read", 24'(port_pin_in & port_mode_digital), 24'(port_read_value));
        check("pin_out", 24'(port_out_value & port_mode_digital), 24'(port_pin_out));
        $display("Test port pins done");
    endtask
    initial begin
        rst = 1'b1;
        power_down_n = 1'b1;
        sample_value = 24'(rand32());
        port_mode_digital = 8'h00;
        port_out_value = 8'h00;
        port_pin_in = 8'h00;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        check("ready_idle", 24'h1, 24'(conversion_ready_n));
        pins_check();
        check("analog_on", 24'h1, 24'(analog_enable));
        read_once();
        read_once();
        // Continuous read with select held low throughout
        host.select(1'b1);
        host.send(CMD_READ_CONTINUOUS);
        host.idle(4);
        for (int k = 0; k < 2; k++) begin
            wait_ready();
            host.idle(10);
            exp_q.push_back(sample_value);
            host.read(24);
            sample_value = 24'(rand32());
        end
        host.send(CMD_STOP_CONTINUOUS);
        host.idle(4);
        host.send(CMD_RESET);
        host.idle(16);
        // Unknown to the port, so the following read shows it was ignored
        host.send(CMD_SELF_GAIN_CALIBRATE);
        repeat (2 * CONV_SIM) @(negedge clk);
        host.select(1'b0);
        $display("Test continuous and reset done");
        read_once();
        power_down_n = 1'b0;
        repeat (8) @(negedge clk);
        check("analog_off", 24'h0, 24'(analog_enable));
        power_down_n = 1'b1;
        repeat (8) @(negedge clk);
        check("analog_back", 24'h1, 24'(analog_enable));
        pins_check();
        $display("Test power down done");
        finish_test();
    end
endmodule
`default_nettype wire
